// ===== hw/ctm_pkg.sv
// Purpose: Constants for the compact 10-bit timer block.
// Assumes: 32-bit APB, one byte register per aligned word.
// Notes:   Offsets are byte addresses.
package ctm_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] CTM_OFS_PIN_EN0  = 8'h00;
  localparam logic [7:0] CTM_OFS_PIN_EN1  = 8'h04;
  localparam logic [7:0] CTM_OFS_CTRL0    = 8'h08;
  localparam logic [7:0] CTM_OFS_CTRL1    = 8'h0C;
  localparam logic [7:0] CTM_OFS_CNT_LO   = 8'h10;
  localparam logic [7:0] CTM_OFS_CNT_HI   = 8'h14;
  localparam logic [7:0] CTM_OFS_DUTY_LO  = 8'h18;
  localparam logic [7:0] CTM_OFS_DUTY_HI  = 8'h1C;
  localparam logic [7:0] CTM_OFS_PIN_INV  = 8'h20;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTM_C0_PAUSE   = 7;
  localparam int CTM_C0_CKS_LSB = 4;
  localparam int CTM_C0_RUN     = 3;
  localparam int CTM_C1_MODE_LSB = 6;
  localparam int CTM_C1_IO_LSB  = 4;
  localparam int CTM_C1_OC      = 3;
  localparam int CTM_C1_POL     = 2;
  localparam int CTM_C1_DPX     = 1;
  localparam int CTM_C1_CCLR    = 0;
  localparam logic [7:0] CTM_RST_BYTE = 8'h00;
  localparam logic [9:0] CTM_CNT_MAX  = 10'h3FF;
  // ****************************************
  // Clock select and mode codes
  // ****************************************
  localparam logic [2:0] CTM_CK_SYS4  = 3'h0;
  localparam logic [2:0] CTM_CK_SYS   = 3'h1;
  localparam logic [2:0] CTM_CK_H16   = 3'h2;
  localparam logic [2:0] CTM_CK_H64   = 3'h3;
  localparam logic [2:0] CTM_CK_SUB   = 3'h4;
  localparam logic [2:0] CTM_CK_RSVD  = 3'h5;
  localparam logic [2:0] CTM_CK_EXTR  = 3'h6;
  localparam logic [2:0] CTM_CK_EXTF  = 3'h7;
  localparam logic [1:0] CTM_MD_CMP   = 2'h0;
  localparam logic [1:0] CTM_MD_PWM   = 2'h2;
  localparam logic [1:0] CTM_MD_TMR   = 2'h3;
  localparam logic [1:0] CTM_IO_LOW   = 2'h1;
  localparam logic [1:0] CTM_IO_HIGH  = 2'h2;
  localparam logic [1:0] CTM_IO_TOG   = 2'h3;
  // Prescaler terminal values for the divided sources.
  localparam logic [5:0] CTM_DIV4_M   = 6'h03;
  localparam logic [5:0] CTM_DIV16_M  = 6'h0F;
  localparam logic [5:0] CTM_DIV64_M  = 6'h3F;
endpackage

// ===== hw/ctm_top.sv
// Purpose: Compact 10-bit timer with APB byte registers.
// Assumes: f_H equals the system clock; sub clock and
//          external clock arrive asynchronously on pins.
// Notes:   Low bytes pass through one shared holding latch.
// Behaviour
// - Ten-bit counter counts up on each selected timer clock tick.
// - Period compare uses counter bits 9..7; duty compare uses all ten.
// - Software cannot load the counter; its one software clear is run-enable rising.
// - Counter clears on overflow or on the selected comparator match.
// - Duty matches raise a duty request; period match or overflow raises a period request only with clear-select 0.
// - Counter byte pair is read-only; duty compare pair is read-write.
// - Low compare byte writes go only into the shared holding latch.
// - High compare byte write also copies the latch into the low byte.
// - High byte read captures the matching low byte into the latch.
// - Low byte reads return the holding latch, not the live byte.
// - Unimplemented register bits read as zero.
// - Pause bit halts counting while the timer stays powered.
// - Counter holds its value in pause and resumes from it.
// - Clock select 0..4 picks fsys/4, fsys, fH/16, fH/64, sub clock.
// - Clock select code 101 supplies no clock to the counter.
// - Codes 110 and 111 count rising and falling external pin edges.
// - Run-enable lets the counter run; clearing it stops the timer.
// - Run-enable rising clears the counter; falling keeps its value.
// - In compare mode run-enable rising restores the initial output level.
// - Each output pin can carry the timer output or its inverse.
// - Pin-enable bit routes its pin to the timer, else other function.
// - Mode 00 compare output, 10 PWM, 11 timer, 01 undefined.
// - Clear-select 0 clears on period match or overflow; 1 on duty match.
// - Period value zero lets the counter overflow after 1024 clocks.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ctm_top
  import ctm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  input  wire logic        sub_clk_i,
  input  wire logic        ext_clk_i,
  output logic [2:0]       timer_pin_o,
  output logic [2:0]       timer_pin_sel_o,
  output logic             duty_match_o,
  output logic             period_match_o
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0]  pin_en0_r;
  logic [2:0]  pin_en1_r;
  logic [2:0]  pin_inv_r;
  logic [7:0]  ctrl0_r;
  logic [7:0]  ctrl1_r;
  logic [9:0]  cnt_r;
  logic [9:0]  duty_r;
  logic [7:0]  latch_r;
  logic [31:0] rdata_r;
  logic        run_d_r;
  logic        out_r;
  logic [2:0]  pin_r;
  logic [2:0]  pin_sel_r;
  logic        amatch_r;
  logic        pmatch_r;
  logic [5:0]  pre_r;
  logic [1:0]  ext_sync_r;
  logic        ext_d_r;
  logic [1:0]  sub_sync_r;
  logic        sub_d_r;

  // ****************************************
  // APB decode
  // ****************************************
  // Setup and access phase qualifiers; the slave never waits.
  wire setup_w  = psel_i & ~penable_i;
  wire access_w = psel_i & penable_i;
  wire wr_w     = access_w & pwrite_i;
  wire rd_w     = access_w & ~pwrite_i;
  wire rd_setup_w = setup_w & ~pwrite_i;
  wire a_pe0    = (paddr_i == CTM_OFS_PIN_EN0);
  wire a_pe1    = (paddr_i == CTM_OFS_PIN_EN1);
  wire a_c0     = (paddr_i == CTM_OFS_CTRL0);
  wire a_c1     = (paddr_i == CTM_OFS_CTRL1);
  wire a_clo    = (paddr_i == CTM_OFS_CNT_LO);
  wire a_chi    = (paddr_i == CTM_OFS_CNT_HI);
  wire a_dlo    = (paddr_i == CTM_OFS_DUTY_LO);
  wire a_dhi    = (paddr_i == CTM_OFS_DUTY_HI);
  wire a_inv    = (paddr_i == CTM_OFS_PIN_INV);
  wire mapped_w = a_pe0 | a_pe1 | a_c0 | a_c1 | a_clo | a_chi | a_dlo | a_dhi | a_inv;
  assign pready_o  = 1'b1;
  assign pslverr_o = access_w & ~mapped_w;
  assign prdata_o  = rdata_r;

  // Read mux; unused upper bits and reserved fields read zero.
  logic [7:0] rmux;
  always_comb begin
    if (a_pe0) begin
      rmux = pin_en0_r;
    end else if (a_pe1) begin
      rmux = {5'h00, pin_en1_r};
    end else if (a_inv) begin
      rmux = {5'h00, pin_inv_r};
    end else if (a_c0) begin
      rmux = ctrl0_r;
    end else if (a_c1) begin
      rmux = ctrl1_r;
    end else if (a_clo | a_dlo) begin
      rmux = latch_r;
    end else if (a_chi) begin
      rmux = {6'h00, cnt_r[9:8]};
    end else if (a_dhi) begin
      rmux = {6'h00, duty_r[9:8]};
    end else begin
      rmux = CTM_RST_BYTE;
    end
  end

  // ****************************************
  // Control fields
  // ****************************************
  wire       pause_w  = ctrl0_r[CTM_C0_PAUSE];
  wire [2:0] cks_w    = ctrl0_r[CTM_C0_CKS_LSB +: 3];
  wire       run_w    = ctrl0_r[CTM_C0_RUN];
  wire [2:0] per_w    = ctrl0_r[2:0];
  wire [1:0] mode_w   = ctrl1_r[CTM_C1_MODE_LSB +: 2];
  wire [1:0] io_w     = ctrl1_r[CTM_C1_IO_LSB +: 2];
  wire       oc_w     = ctrl1_r[CTM_C1_OC];
  wire       pol_w    = ctrl1_r[CTM_C1_POL];
  wire       dpx_w    = ctrl1_r[CTM_C1_DPX];
  wire       cclr_w   = ctrl1_r[CTM_C1_CCLR];
  wire       run_rise = run_w & ~run_d_r;

  // ****************************************
  // Clock source selection
  // ****************************************
  // Pins pass two flops; edge detection reads only the second.
  wire ext_rise = ext_sync_r[1] & ~ext_d_r;
  wire ext_fall = ~ext_sync_r[1] & ext_d_r;
  wire sub_rise = sub_sync_r[1] & ~sub_d_r;
  logic tick_src;
  always_comb begin
    case (cks_w)
      CTM_CK_SYS4: tick_src = (pre_r[1:0] == CTM_DIV4_M[1:0]);
      CTM_CK_SYS:  tick_src = 1'b1;
      CTM_CK_H16:  tick_src = (pre_r[3:0] == CTM_DIV16_M[3:0]);
      CTM_CK_H64:  tick_src = (pre_r == CTM_DIV64_M);
      CTM_CK_SUB:  tick_src = sub_rise;
      CTM_CK_EXTR: tick_src = ext_rise;
      CTM_CK_EXTF: tick_src = ext_fall;
      default:     tick_src = 1'b0;
    endcase
  end
  // Counting needs run on and pause off.
  wire tick_w = tick_src & run_w & ~pause_w;

  // ****************************************
  // Comparators and clear
  // ****************************************
  // Period match fires on the last count of the period so that
  // the period is exactly value times 128 clocks.
  wire [9:0] cnt_inc  = cnt_r + 10'h001;
  wire       ovf_w    = (cnt_r == CTM_CNT_MAX);
  wire       pm_w     = (per_w != 3'h0) & (cnt_inc[9:7] == per_w) & (cnt_inc[6:0] == 7'h00);
  wire       am_w     = (cnt_r == duty_r) & (duty_r != 10'h000);
  wire       clr_p    = ~cclr_w & (pm_w | (per_w == 3'h0 & ovf_w));
  wire       clr_a    = cclr_w & (am_w | ((duty_r == 10'h000) & ovf_w));
  wire       clr_w    = clr_p | clr_a | ovf_w;

  // Counter; no software load path exists.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_r <= 10'h000;
    end else if (run_rise) begin
      cnt_r <= 10'h000;
    end else if (tick_w) begin
      cnt_r <= clr_w ? 10'h000 : cnt_inc;
    end
  end

  // Request pulses; period requests vanish with clear-select high.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      amatch_r <= 1'b0;
      pmatch_r <= 1'b0;
    end else begin
      amatch_r <= tick_w & am_w;
      pmatch_r <= tick_w & ~cclr_w & (pm_w | (per_w == 3'h0 & ovf_w));
    end
  end
  assign duty_match_o   = amatch_r;
  assign period_match_o = pmatch_r;

  // ****************************************
  // Timer output
  // ****************************************
  // PWM active while the counter is below the duty value; the
  // duplex bit swaps which compare sets the duty.
  wire [9:0] pwm_duty = dpx_w ? {per_w, 7'h00} : duty_r;
  wire       pwm_on   = (cnt_r < pwm_duty) ? oc_w : ~oc_w;
  logic      cmp_nxt;
  always_comb begin
    case (io_w)
      CTM_IO_LOW:  cmp_nxt = 1'b0;
      CTM_IO_HIGH: cmp_nxt = 1'b1;
      CTM_IO_TOG:  cmp_nxt = ~out_r;
      default:     cmp_nxt = out_r;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_r <= 1'b0;
    end else if (mode_w == CTM_MD_CMP) begin
      if (run_rise) begin
        out_r <= oc_w;
      end else if (tick_w & am_w) begin
        out_r <= cmp_nxt;
      end
    end else if (mode_w == CTM_MD_PWM) begin
      out_r <= run_w & pwm_on;
    end
  end

  // Pin routing: each enabled pin carries output or its inverse.
  wire       pol_out  = (mode_w == CTM_MD_TMR) ? out_r : (out_r ^ pol_w);
  wire [2:0] pin_nxt  = pin_en0_r[2:0] & ({3{pol_out}} ^ pin_inv_r);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_r     <= 3'h0;
      pin_sel_r <= 3'h0;
    end else begin
      pin_r     <= pin_nxt;
      pin_sel_r <= pin_en0_r[2:0];
    end
  end
  assign timer_pin_o     = pin_r;
  assign timer_pin_sel_o = pin_sel_r;

  // ****************************************
  // Synchronisers and prescaler
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_sync_r <= 2'h0;
      ext_d_r    <= 1'b0;
      sub_sync_r <= 2'h0;
      sub_d_r    <= 1'b0;
      pre_r      <= 6'h00;
      run_d_r    <= 1'b0;
    end else begin
      ext_sync_r <= {ext_sync_r[0], ext_clk_i};
      ext_d_r    <= ext_sync_r[1];
      sub_sync_r <= {sub_sync_r[0], sub_clk_i};
      sub_d_r    <= sub_sync_r[1];
      pre_r      <= pre_r + 6'h01;
      run_d_r    <= run_w;
    end
  end

  // ****************************************
  // Register writes and byte latch
  // ****************************************
  // Read data is loaded in setup so it is stable in access.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (setup_w) begin
      rdata_r <= {24'h00_0000, rmux};
    end
  end

  // Control and pin registers.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_en0_r <= CTM_RST_BYTE;
      pin_en1_r <= 3'h0;
      pin_inv_r <= 3'h0;
      ctrl0_r   <= CTM_RST_BYTE;
      ctrl1_r   <= CTM_RST_BYTE;
    end else if (wr_w) begin
      if (a_pe0) begin
        pin_en0_r <= pwdata_i[7:0];
      end else if (a_pe1) begin
        pin_en1_r <= pwdata_i[2:0];
      end else if (a_inv) begin
        pin_inv_r <= pwdata_i[2:0];
      end else if (a_c0) begin
        ctrl0_r <= pwdata_i[7:0];
      end else if (a_c1) begin
        ctrl1_r <= pwdata_i[7:0];
      end
    end
  end

  // Shared latch and duty pair; counter bytes are never written.
  // The counter low byte is caught at setup, the same edge that samples the high byte.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      latch_r <= CTM_RST_BYTE;
      duty_r  <= 10'h000;
    end else if (wr_w & a_dlo) begin
      latch_r <= pwdata_i[7:0];
    end else if (wr_w & a_dhi) begin
      duty_r <= {pwdata_i[1:0], latch_r};
    end else if (rd_setup_w & a_chi) begin
      latch_r <= cnt_r[7:0];
    end else if (rd_w & a_dhi) begin
      latch_r <= duty_r[7:0];
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_RUN_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    run_rise |=> cnt_r == 10'h000) else $error("Run rise did not clear counter.");
  AST_PAUSE_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (pause_w & ~run_rise) |=> $stable(cnt_r)) else $error("Counter moved in pause.");
  AST_RSVD_CK: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cks_w == CTM_CK_RSVD & run_w & ~run_rise) |=> $stable(cnt_r))
    else $error("Reserved clock advanced counter.");
  AST_OFF_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (~run_w) |=> $stable(cnt_r)) else $error("Counter moved while off.");
  AST_COUNT_UP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (tick_w & ~clr_w & ~run_rise) |=> cnt_r == $past(cnt_r) + 10'h001)
    else $error("Counter did not step by one.");
  AST_LO_WR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_w & a_dlo) |=> (latch_r == $past(pwdata_i[7:0])) && $stable(duty_r))
    else $error("Low write touched live byte.");
  AST_HI_WR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_w & a_dhi) |=> duty_r == {$past(pwdata_i[1:0]), $past(latch_r)})
    else $error("High write did not copy latch.");
  AST_HI_RD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rd_setup_w & a_chi) |=> latch_r == $past(cnt_r[7:0]))
    else $error("High read did not capture low byte.");
  AST_EXT_ONCE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cks_w == CTM_CK_EXTR & ~run_rise & ~ext_rise) |=> $stable(cnt_r))
    else $error("Counter moved without a pin edge.");
  AST_NO_PF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cclr_w |=> ~pmatch_r) else $error("Period request with clear-select high.");
  AST_CMP_INIT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (run_rise & mode_w == CTM_MD_CMP) |=> out_r == $past(oc_w))
    else $error("Output not restored to initial level.");
  // Clear paths, counter byte writes and low reads, pin disable and clock source checks.
  AST_DUTY_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cclr_w & tick_w & am_w & ~run_rise) |=> cnt_r == 10'h000)
    else $error("Duty match did not clear counter.");
  AST_PER_CLR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (~cclr_w & tick_w & pm_w & ~run_rise) |=> cnt_r == 10'h000)
    else $error("Period match did not clear counter.");
  AST_OVF_WRAP: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (tick_w & ovf_w & ~run_rise) |=> cnt_r == 10'h000)
    else $error("Counter did not clear on overflow.");
  AST_RO_CNT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_w & (a_clo | a_chi) & ~tick_w & ~run_rise) |=> $stable(cnt_r))
    else $error("Counter byte write changed counter.");
  AST_LO_RD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (setup_w & (a_clo | a_dlo)) |=> rdata_r == {24'h00_0000, $past(latch_r)})
    else $error("Low byte read did not return latch.");
  AST_PIN_OFF: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (~pin_en0_r[0]) |=> timer_pin_o[0] == 1'b0) else $error("Disabled pin carries timer output.");
  AST_CK_SYS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cks_w == CTM_CK_SYS & run_w & ~pause_w & ~run_rise & ~clr_w) |=> cnt_r == $past(cnt_r) + 10'h001)
    else $error("System clock select missed a count.");
  AST_EXT_FALL: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (cks_w == CTM_CK_EXTF & run_w & ~pause_w & ~run_rise & ext_fall & ~clr_w)
    |=> cnt_r == $past(cnt_r) + 10'h001)
    else $error("Falling pin edge not counted.");
endmodule
`default_nettype wire

// ===== sim/ctm_tb.sv
// Purpose: Self-checking bench for the compact 10-bit timer block.
// Assumes: Zero-wait APB slave; the bench makes the sub clock at fsys/8.
// Notes:   Tick rates are measured as clocks between match pulses.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ctm_pkg::*;
  logic        clk_i;
  logic        sys_rst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic        ext_clk_i;
  logic [2:0]  sub_div = 3'h0;
  wire         sub_clk_i = sub_div[2];
  logic        pready_o;
  logic        pslverr_o;
  logic [31:0] prdata_o;
  logic [2:0]  timer_pin_o;
  logic [2:0]  timer_pin_sel_o;
  logic        duty_match_o;
  logic        period_match_o;
  int          mismatches = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n;
  int          exp_gap [5] = '{40, 10, 160, 640, 80};
  logic [31:0] q;
  logic        e;
  logic [9:0]  c1;
  logic [9:0]  c2;

  ctm_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .sub_clk_i(sub_clk_i), .ext_clk_i(ext_clk_i),
    .timer_pin_o(timer_pin_o), .timer_pin_sel_o(timer_pin_sel_o), .duty_match_o(duty_match_o),
    .period_match_o(period_match_o));

  // ****************************************
  // Clocks and run limit
  // ****************************************
  // The system clock runs at 100 MHz.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Sub clock divider and the watchdog on the run length.
  always @(posedge clk_i) begin
    sub_div <= sub_div + 3'h1;
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      $display("[ERR] %0t run limit reached", $time);
      end_of_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compares a design value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t value %0h expected %0h", $time, got, exp);
    end
  endtask

  // Compares a measured count of clocks.
  task automatic chk_n(input int got, input int exp);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("[ERR] %0t interval %0d expected %0d", $time, got, exp);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    if (k >= 50) begin
      mismatches++;
      $display("[ERR] %0t no bus answer", $time);
    end
    rq = prdata_o;
    re = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Writes one register.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, q, e);
  endtask

  // Reads one register and compares it.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] d);
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(q, {24'h00_0000, d});
  endtask

  // Reads the counter, high byte first.
  task automatic rd_cnt(output logic [9:0] c);
    apb(1'b0, CTM_OFS_CNT_HI, 32'h0000_0000, q, e);
    c[9:8] = q[1:0];
    apb(1'b0, CTM_OFS_CNT_LO, 32'h0000_0000, q, e);
    c[7:0] = q[7:0];
  endtask

  // Restarts the timer so the counter starts from zero.
  task automatic run(input logic [7:0] v);
    wr(CTM_OFS_CTRL0, v & 8'hF7);
    wr(CTM_OFS_CTRL0, v);
  endtask

  // Clocks from one match pulse to the next.
  task automatic gap(input logic which, output int g);
    int k;
    k = 0;
    g = 0;
    do begin
      @(negedge clk_i);
      k++;
    end while ((which ? period_match_o : duty_match_o) !== 1'b1 && k < 3000);
    do begin
      @(negedge clk_i);
      g++;
    end while ((which ? period_match_o : duty_match_o) !== 1'b1 && g < 3000);
  endtask

  // Toggles the external pin 2n+1 times: n+1 rising and n falling edges.
  task automatic ext_train(input int t);
    for (int i = 0; i < 2 * t + 1; i++) begin
      @(posedge clk_i);
      ext_clk_i <= ~ext_clk_i;
      repeat (4) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask

  // Counts the clocks in one 128-clock window in which pin 0 is high.
  task automatic hi_count(output int h);
    h = 0;
    repeat (128) begin
      @(negedge clk_i);
      if (timer_pin_o[0] === 1'b1) begin
        h++;
      end
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  // Resets the block, then walks through the scenarios.
  initial begin
    sys_rst_i <= 1'b1;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    pwrite_i <= 1'b0;
    paddr_i <= 8'h00;
    pwdata_i <= 32'h0000_0000;
    ext_clk_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 0; a <= 32; a += 4) rdchk(8'(a), 8'h00);
    apb(1'b0, 8'h24, 32'h0000_0000, q, e);
    chk(e, 1'b1);
    chk(q, 32'h0000_0000);
    wr(CTM_OFS_PIN_EN1, 8'hFF);
    rdchk(CTM_OFS_PIN_EN1, 8'h07);
    wr(CTM_OFS_PIN_EN0, 8'h05);
    rdchk(CTM_OFS_PIN_EN0, 8'h05);
    chk(timer_pin_sel_o, 3'b101);
    // Duty pair goes through the shared holding latch.
    wr(CTM_OFS_DUTY_LO, 8'h55);
    rdchk(CTM_OFS_DUTY_HI, 8'h00);
    rdchk(CTM_OFS_DUTY_LO, 8'h00);
    wr(CTM_OFS_DUTY_LO, 8'hA5);
    wr(CTM_OFS_DUTY_HI, 8'hFF);
    rdchk(CTM_OFS_DUTY_HI, 8'h03);
    rdchk(CTM_OFS_DUTY_LO, 8'hA5);
    wr(CTM_OFS_DUTY_LO, 8'h11);
    rdchk(CTM_OFS_DUTY_LO, 8'h11);
    rdchk(CTM_OFS_DUTY_HI, 8'h03);
    rdchk(CTM_OFS_DUTY_LO, 8'hA5);
    // Pause, resume, stop, write attempts and restart.
    wr(CTM_OFS_CTRL0, 8'h18);
    repeat (30) @(posedge clk_i);
    wr(CTM_OFS_CTRL0, 8'h98);
    rd_cnt(c1);
    repeat (20) @(posedge clk_i);
    rd_cnt(c2);
    chk(c2, c1);
    wr(CTM_OFS_CTRL0, 8'h18);
    repeat (10) @(posedge clk_i);
    rd_cnt(c2);
    chk(c2 > c1, 1'b1);
    wr(CTM_OFS_CTRL0, 8'h10);
    rd_cnt(c1);
    wr(CTM_OFS_CNT_HI, 8'h03);
    wr(CTM_OFS_CNT_LO, 8'hFF);
    repeat (10) @(posedge clk_i);
    rd_cnt(c2);
    chk(c2, c1);
    wr(CTM_OFS_CTRL0, 8'h18);
    rd_cnt(c2);
    chk(c2 < 10'h010, 1'b1);
    // Clock sources timed by duty match clears at duty 9.
    wr(CTM_OFS_DUTY_LO, 8'h09);
    wr(CTM_OFS_DUTY_HI, 8'h00);
    wr(CTM_OFS_CTRL1, 8'h01);
    for (int i = 0; i < 5; i++) begin
      run({1'b0, 3'(i), 4'h8});
      gap(1'b0, n);
      chk_n(n, exp_gap[i]);
    end
    run(8'h58);
    repeat (50) @(posedge clk_i);
    rd_cnt(c1);
    chk(c1, 10'h000);
    // Period comparator on the top three bits, and overflow.
    wr(CTM_OFS_CTRL1, 8'h00);
    run(8'h19);
    gap(1'b1, n);
    chk_n(n, 128);
    run(8'h18);
    gap(1'b1, n);
    chk_n(n, 1024);
    // External pin edges, rising then falling.
    wr(CTM_OFS_CTRL0, 8'h60);
    wr(CTM_OFS_CTRL0, 8'h68);
    ext_train(4);
    rd_cnt(c1);
    chk(c1, 10'h005);
    wr(CTM_OFS_CTRL0, 8'h70);
    ext_clk_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wr(CTM_OFS_CTRL0, 8'h78);
    ext_train(4);
    rd_cnt(c1);
    chk(c1, 10'h004);
    // Compare output: initial high, low on duty match, inversion.
    wr(CTM_OFS_PIN_EN0, 8'h07);
    wr(CTM_OFS_CTRL1, 8'h19);
    run(8'h18);
    repeat (3) @(negedge clk_i);
    chk(timer_pin_o, 3'b111);
    repeat (20) @(negedge clk_i);
    chk(timer_pin_o, 3'b000);
    wr(CTM_OFS_PIN_INV, 8'h02);
    repeat (3) @(negedge clk_i);
    chk(timer_pin_o, 3'b010);
    run(8'h18);
    repeat (3) @(negedge clk_i);
    chk(timer_pin_o, 3'b101);
    wr(CTM_OFS_PIN_EN0, 8'h00);
    repeat (3) @(negedge clk_i);
    chk(timer_pin_o, 3'b000);
    chk(timer_pin_sel_o, 3'b000);
    // PWM is active high below the duty value 9 in a 128-clock period, then inverted.
    wr(CTM_OFS_PIN_EN0, 8'h01);
    wr(CTM_OFS_CTRL1, 8'hA8);
    run(8'h19);
    hi_count(n);
    hi_count(n);
    chk_n(n, 9);
    wr(CTM_OFS_CTRL1, 8'hAC);
    repeat (4) @(negedge clk_i);
    hi_count(n);
    chk_n(n, 119);
    for (int m = 0; m < 4; m++) begin
      wr(CTM_OFS_CTRL1, {2'(m), 6'h00});
      rdchk(CTM_OFS_CTRL1, {2'(m), 6'h00});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
